// >>> src/ctl_defines.svh
/*
 * Constants for the 2-wire register access link: address fields,
 * byte counts, timing counts and the default target address.
 * Assumes inclusion by bare name from the target and controller modules.
 */
`ifndef CTL_DEFINES_SVH
`define CTL_DEFINES_SVH

`define CTL_SPACE_MSB 23
`define CTL_SPACE_LSB 16
`define CTL_LOC_MSB 15
`define CTL_LOC_LSB 0
`define CTL_TARGET_ADDR 7'h59
`define CTL_ADDR_BYTES 3
`define CTL_DATA_BYTES 3
`define CTL_HALF_BIT 16'h0010
`define CTL_SPACES 4
`define CTL_LOCS 16

`endif

// >>> src/ctl_pkg.sv
/*
 * Types shared by both ends of the 2-wire register link.
 * Assumes ctl_defines.svh is on the include path.
 */
package ctl_pkg;
	typedef logic [23:0] word24_t;
	typedef logic [7:0] byte_t;
	typedef enum logic [2:0]
	{
		DEV_IDLE = 3'b000,
		DEV_RECV = 3'b001,
		DEV_ACK = 3'b010,
		DEV_SEND = 3'b011,
		DEV_MACK = 3'b100,
		DEV_SKIP = 3'b101
	} dev_state_t;
	typedef enum logic [3:0]
	{
		HOST_IDLE = 4'h0,
		HOST_START = 4'h1,
		HOST_BIT_LO = 4'h2,
		HOST_BIT_HI = 4'h3,
		HOST_ACK_LO = 4'h4,
		HOST_ACK_HI = 4'h5,
		HOST_STOP_LO = 4'h6,
		HOST_STOP_HI = 4'h7,
		HOST_RS_LO = 4'h8,
		HOST_RS_HI = 4'h9,
		HOST_DONE = 4'hA
	} host_state_t;
endpackage : ctl_pkg

// >>> src/ctl_link_if.sv
/*
 * Two-wire control link between controller and target.
 * Both wires are open drain; pulled high when nobody drives.
 */
`timescale 1ns/100ps
interface ctl_link_if;
	logic scl_out;
	logic scl_oe;
	logic sda_host_out;
	logic sda_host_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic scl;
	logic sda;
	assign scl = !(scl_oe && !scl_out);
	assign sda = !((sda_host_oe && !sda_host_out) ||
		(sda_dev_oe && !sda_dev_out));
	modport host
	(
		output scl_out, scl_oe, sda_host_out, sda_host_oe,
		input scl, sda
	);
	modport device
	(
		output sda_dev_out, sda_dev_oe,
		input scl, sda
	);
endinterface : ctl_link_if

// >>> src/ctl_target.sv
/*
 * Target end: decodes link transfers and reads or writes a small
 * internal register store selected by space and location fields.
 * Assumes scl and sda are synchronous to clock and pulled high.
 */
`timescale 1ns/100ps
`include "ctl_defines.svh"
module ctl_target
	import ctl_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = `CTL_TARGET_ADDR,
	parameter int SPACES = `CTL_SPACES,
	parameter int LOCS = `CTL_LOCS
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Link
	ctl_link_if.device link,
	// Status
	output logic write_strobe,
	output word24_t last_address,
	output word24_t last_data
);
	typedef struct packed
	{
		dev_state_t state;
		logic scl_d;
		logic sda_d;
		byte_t shift;
		logic [3:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic reading;
		logic sda_lo;
		word24_t addr;
		word24_t data;
		logic wr;
	} state_t;
	state_t r;
	state_t next_r;
	word24_t mem [SPACES*LOCS];
	logic start_seen;
	logic stop_seen;
	logic scl_rise;
	logic scl_fall;
	logic hit;
	int idx;
	function automatic int slot(input word24_t a);
		// Space from top byte, location from low word
		return int'(a[`CTL_SPACE_MSB:`CTL_SPACE_LSB]) % SPACES * LOCS
			+ int'(a[`CTL_LOC_MSB:`CTL_LOC_LSB]) % LOCS;
	endfunction : slot
	assign start_seen = r.scl_d && link.scl && r.sda_d && !link.sda;
	assign stop_seen = r.scl_d && link.scl && !r.sda_d && link.sda;
	assign scl_rise = !r.scl_d && link.scl;
	assign scl_fall = r.scl_d && !link.scl;
	assign idx = slot(r.addr);
	// Outputs only drive low, target never drives the clock
	assign link.sda_dev_out = 1'b0;
	assign link.sda_dev_oe = r.sda_lo;
	assign write_strobe = r.wr;
	assign last_address = r.addr;
	assign last_data = r.data;
	assign hit = r.shift[7:1] == TARGET_ADDR;
	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		next_r = r;
		next_r.scl_d = link.scl;
		next_r.sda_d = link.sda;
		next_r.wr = 1'b0;
		if (start_seen)
		begin
			// Start or repeated start
			next_r.state = DEV_RECV;
			next_r.bit_cnt = 4'h0;
			next_r.byte_cnt = 3'h0;
			next_r.sda_lo = 1'b0;
		end
		else if (stop_seen)
		begin
			next_r.state = DEV_IDLE;
			next_r.sda_lo = 1'b0;
		end
		else
		begin
			case (r.state)
			DEV_IDLE:
			begin
				next_r.sda_lo = 1'b0;
			end
			DEV_RECV:
			begin
				if (scl_rise)
				begin
					next_r.shift = {r.shift[6:0], link.sda};
					next_r.bit_cnt = r.bit_cnt + 4'h1;
				end
				else if (scl_fall && r.bit_cnt == 4'h8)
				begin
					next_r.bit_cnt = 4'h0;
					if (r.byte_cnt == 3'h0)
					begin
						if (!hit)
							next_r.state = DEV_SKIP;
						else
						begin
							next_r.state = DEV_ACK;
							next_r.sda_lo = 1'b1;
							next_r.reading = r.shift[0];
						end
					end
					else
					begin
						next_r.state = DEV_ACK;
						next_r.sda_lo = 1'b1;
						if (r.byte_cnt <= 3'h3)
							next_r.addr = {r.addr[15:0], r.shift};
						else
							next_r.data = {r.data[15:0], r.shift};
						if (r.byte_cnt == 3'h6)
							next_r.wr = 1'b1;
					end
				end
			end
			DEV_ACK:
			begin
				if (scl_fall)
				begin
					next_r.byte_cnt = r.byte_cnt + 3'h1;
					if (r.reading)
					begin
						next_r.data = mem[idx];
						next_r.state = DEV_SEND;
						next_r.sda_lo = !mem[idx][23];
						next_r.shift = mem[idx][23:16];
					end
					else
					begin
						next_r.state = DEV_RECV;
						next_r.sda_lo = 1'b0;
					end
				end
			end
			DEV_SEND:
			begin
				if (scl_fall)
				begin
					next_r.bit_cnt = r.bit_cnt + 4'h1;
					next_r.shift = {r.shift[6:0], 1'b0};
					if (r.bit_cnt == 4'h7)
					begin
						next_r.state = DEV_MACK;
						next_r.sda_lo = 1'b0;
						next_r.bit_cnt = 4'h0;
					end
					else
						next_r.sda_lo = !r.shift[6];
				end
			end
			DEV_MACK:
			begin
				if (scl_rise && link.sda)
					next_r.state = DEV_SKIP;
				else if (scl_fall)
				begin
					next_r.data = {r.data[15:0], 8'h00};
					next_r.shift = r.data[15:8];
					next_r.sda_lo = !r.data[15];
					next_r.state = DEV_SEND;
				end
			end
			DEV_SKIP:
			begin
				next_r.sda_lo = 1'b0;
			end
			default:
			begin
				next_r.state = DEV_IDLE;
			end
			endcase
		end
	end
	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			r <= '0;
			r.scl_d <= 1'b1;
			r.sda_d <= 1'b1;
		end
		else
			r <= next_r;
	end
	always_ff @(posedge clock)
	begin
		if (r.wr)
			mem[idx] <= r.data;
	end
endmodule : ctl_target

// >>> src/ctl_controller.sv
/*
 * Controller end: issues register writes and reads on the link.
 * Assumes a pull-up on both wires and a target that stretches no clock.
 */
`timescale 1ns/100ps
`include "ctl_defines.svh"
module ctl_controller
	import ctl_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = `CTL_TARGET_ADDR,
	parameter logic [15:0] HALF_BIT = `CTL_HALF_BIT
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Link
	ctl_link_if.host link,
	// Request
	input wire logic req_valid,
	input wire logic req_read,
	input wire word24_t req_addr,
	input wire word24_t req_data,
	output logic req_ready,
	// Answer
	output logic done,
	output logic nacked,
	output word24_t rd_data
);
	typedef struct packed
	{
		host_state_t state;
		logic [15:0] tick;
		logic [3:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic read;
		logic phase;
		byte_t shift;
		word24_t addr;
		word24_t data;
		logic scl_lo;
		logic sda_lo;
		logic err;
		logic done;
	} state_t;
	state_t r;
	state_t next_r;
	logic step;
	function automatic byte_t tx_byte(input state_t s);
		// Byte order of a write or dummy write
		case (s.byte_cnt)
		3'h0: return {TARGET_ADDR, s.phase};
		3'h1: return s.addr[23:16];
		3'h2: return s.addr[15:8];
		3'h3: return s.addr[7:0];
		3'h4: return s.data[23:16];
		3'h5: return s.data[15:8];
		default: return s.data[7:0];
		endcase
	endfunction : tx_byte
	assign step = r.tick == HALF_BIT;
	assign link.scl_out = 1'b0;
	assign link.scl_oe = r.scl_lo;
	assign link.sda_host_out = 1'b0;
	assign link.sda_host_oe = r.sda_lo;
	assign req_ready = r.state == HOST_IDLE;
	assign done = r.done;
	assign nacked = r.err;
	assign rd_data = r.data;
	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.tick = step ? 16'h0000 : r.tick + 16'h0001;
		if (r.state == HOST_IDLE)
		begin
			next_r.tick = 16'h0000;
			if (req_valid)
			begin
				next_r.read = req_read;
				next_r.addr = req_addr;
				next_r.data = req_data;
				next_r.phase = 1'b0;
				next_r.byte_cnt = 3'h0;
				next_r.err = 1'b0;
				next_r.sda_lo = 1'b1;
				next_r.state = HOST_START;
			end
		end
		else if (step)
		begin
			case (r.state)
			HOST_START:
			begin
				next_r.scl_lo = 1'b1;
				next_r.bit_cnt = 4'h0;
				next_r.shift = tx_byte(r);
				next_r.state = HOST_BIT_LO;
			end
			HOST_BIT_LO:
			begin
				if (r.phase && r.byte_cnt != 3'h0)
					next_r.sda_lo = 1'b0;
				else
					next_r.sda_lo = !r.shift[7];
				next_r.scl_lo = 1'b0;
				next_r.state = HOST_BIT_HI;
			end
			HOST_BIT_HI:
			begin
				next_r.shift = {r.shift[6:0], link.sda};
				next_r.scl_lo = 1'b1;
				next_r.bit_cnt = r.bit_cnt + 4'h1;
				next_r.state = r.bit_cnt == 4'h7 ? HOST_ACK_LO : HOST_BIT_LO;
			end
			HOST_ACK_LO:
			begin
				// Read bytes: ack first two, nack third
				if (r.phase && r.byte_cnt != 3'h0)
					next_r.sda_lo = r.byte_cnt != 3'h3;
				else
					next_r.sda_lo = 1'b0;
				if (r.phase && r.byte_cnt != 3'h0)
					next_r.data = {r.data[15:0], r.shift};
				next_r.scl_lo = 1'b0;
				next_r.state = HOST_ACK_HI;
			end
			HOST_ACK_HI:
			begin
				next_r.scl_lo = 1'b1;
				next_r.bit_cnt = 4'h0;
				next_r.byte_cnt = r.byte_cnt + 3'h1;
				next_r.shift = 8'hFF;
				next_r.sda_lo = 1'b0;
				next_r.state = HOST_BIT_LO;
				if (!(r.phase && r.byte_cnt != 3'h0) && link.sda)
				begin
					next_r.err = 1'b1;
					next_r.state = HOST_STOP_LO;
				end
				else if (r.phase && r.byte_cnt == 3'h3)
					next_r.state = HOST_STOP_LO;
				else if (r.read && !r.phase && r.byte_cnt == 3'h3)
					next_r.state = HOST_RS_LO;
				else if (r.byte_cnt == 3'h6)
					next_r.state = HOST_STOP_LO;
				else if (!r.phase)
				begin
					next_r.shift = tx_byte('{state: r.state, tick: r.tick,
						bit_cnt: r.bit_cnt, byte_cnt: r.byte_cnt + 3'h1,
						read: r.read, phase: r.phase, shift: r.shift,
						addr: r.addr, data: r.data, scl_lo: r.scl_lo,
						sda_lo: r.sda_lo, err: r.err, done: r.done});
				end
			end
			HOST_RS_LO:
			begin
				next_r.sda_lo = 1'b0;
				next_r.scl_lo = 1'b0;
				next_r.state = HOST_RS_HI;
			end
			HOST_RS_HI:
			begin
				// Repeated start, then address with read
				next_r.sda_lo = 1'b1;
				next_r.phase = 1'b1;
				next_r.byte_cnt = 3'h0;
				next_r.data = 24'h000000;
				next_r.state = HOST_START;
			end
			HOST_STOP_LO:
			begin
				next_r.sda_lo = 1'b1;
				next_r.scl_lo = 1'b0;
				next_r.state = HOST_STOP_HI;
			end
			HOST_STOP_HI:
			begin
				next_r.sda_lo = 1'b0;
				next_r.state = HOST_DONE;
			end
			HOST_DONE:
			begin
				next_r.done = 1'b1;
				next_r.state = HOST_IDLE;
			end
			default:
			begin
				next_r.state = HOST_IDLE;
			end
			endcase
		end
	end
	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (!resetn)
			r <= '0;
		else
			r <= next_r;
	end
endmodule : ctl_controller

// >>> dv/ctl_link_asserts.sv
/*
 * Checker for the 2-wire link between controller and target.
 * Assumes one clock domain and a half bit of three clocks.
 */
`timescale 1ns/100ps
module ctl_link_asserts
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Controller drive
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_host_out,
	input wire logic sda_host_oe,
	// Target drive
	input wire logic sda_dev_out,
	input wire logic sda_dev_oe,
	// Resolved wires
	input wire logic scl,
	input wire logic sda
);
	// ********
	// Frame tracking
	// ********
	logic [3:0] bits;
	logic [2:0] nbyte;
	logic rd;
	logic scl_q;
	logic sda_q;
	logic rise;
	logic start_c;
	logic stop_c;
	assign rise = scl && !scl_q;
	assign start_c = scl && scl_q && sda_q && !sda;
	assign stop_c = scl && scl_q && !sda_q && sda;
	always_ff @(posedge clock)
	begin
		scl_q <= scl;
		sda_q <= sda;
		if (!resetn || start_c)
		begin
			bits <= 4'h0;
			nbyte <= 3'h0;
			rd <= 1'b0;
		end
		else if (rise)
		begin
			bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
			if (bits == 4'h8)
				nbyte <= nbyte + 3'h1;
			if (bits == 4'h7 && nbyte == 3'h0)
				rd <= sda;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	a_open_drain: assert property (
		!scl_out && !sda_host_out && !sda_dev_out)
		else $error("link driven high");
	a_half_high: assert property ($rose(scl) |-> scl[*3])
		else $error("clock high phase short");
	a_half_low: assert property ($fell(scl) |-> !scl[*3])
		else $error("clock low phase short");
	a_dev_no_start: assert property ($rose(sda_dev_oe) |-> !scl)
		else $error("target moved data with clock high");
	a_dev_no_stop: assert property ($fell(sda_dev_oe) |-> !scl)
		else $error("target released data with clock high");
	a_dev_acks: assert property (
		rise && bits == 4'h8 && (!rd || nbyte == 3'h0)
		|-> !sda && sda_dev_oe)
		else $error("target byte not acked");
	a_host_acks: assert property (
		rise && bits == 4'h8 && rd && nbyte inside {3'h1, 3'h2}
		|-> !sda && sda_host_oe)
		else $error("controller did not ack");
	a_host_nacks: assert property (
		rise && bits == 4'h8 && rd && nbyte == 3'h3
		|-> sda ##[1:20] stop_c)
		else $error("third byte not nacked then stopped");
	a_host_quiet: assert property (
		rd && nbyte inside {3'h1, 3'h2, 3'h3} && bits != 4'h0 && scl
		&& !(rise && bits == 4'h8)
		|-> !sda_host_oe)
		else $error("controller drove read data");
	a_frame_len: assert property (
		stop_c |-> bits == 4'h1 && nbyte == (rd ? 3'h4 : 3'h7))
		else $error("wrong byte count in frame");
	cover property (stop_c && !rd);
	cover property (stop_c && rd);
	cover property (start_c && nbyte == 3'h4);
endmodule : ctl_link_asserts

// >>> dv/testbench.sv
/*
 * Bench joining controller and target over the link.
 * Assumes design sources and the checker are compiled first.
 */
`timescale 1ns/100ps
module testbench;
	import ctl_pkg::*;
	typedef struct {logic rd; word24_t a; word24_t d;} note_t;
	logic clock;
	logic resetn;
	logic req_valid;
	logic req_read;
	logic req_ready;
	logic done;
	logic nacked;
	logic write_strobe;
	word24_t req_addr;
	word24_t req_data;
	word24_t rd_data;
	word24_t last_address;
	word24_t last_data;
	word24_t addr [8];
	word24_t data [8];
	note_t notes [$];
	note_t e;
	int failures;
	int n_tests;
	int seed;
	int cycles;
	int strobes;
	ctl_link_if u_ctl_link_if();
	ctl_controller #(.HALF_BIT(16'h0002)) u_ctl_controller
	(
		.clock(clock), .resetn(resetn), .link(u_ctl_link_if),
		.req_valid(req_valid), .req_read(req_read),
		.req_addr(req_addr), .req_data(req_data),
		.req_ready(req_ready), .done(done), .nacked(nacked),
		.rd_data(rd_data)
	);
	ctl_target u_ctl_target
	(
		.clock(clock), .resetn(resetn), .link(u_ctl_link_if),
		.write_strobe(write_strobe), .last_address(last_address),
		.last_data(last_data)
	);
	ctl_link_asserts u_ctl_link_asserts
	(
		.clock(clock), .resetn(resetn),
		.scl_out(u_ctl_link_if.scl_out), .scl_oe(u_ctl_link_if.scl_oe),
		.sda_host_out(u_ctl_link_if.sda_host_out),
		.sda_host_oe(u_ctl_link_if.sda_host_oe),
		.sda_dev_out(u_ctl_link_if.sda_dev_out),
		.sda_dev_oe(u_ctl_link_if.sda_dev_oe),
		.scl(u_ctl_link_if.scl), .sda(u_ctl_link_if.sda)
	);
	// ********
	// Tasks
	// ********
	task automatic check_word(input word24_t got, input word24_t exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check_word
	task automatic report_and_stop;
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	task automatic xfer(input logic rd, input int i);
		while (req_ready !== 1'b1)
			@(negedge clock);
		req_valid = 1'b1;
		req_read = rd;
		req_addr = addr[i];
		req_data = rd ? 24'($random(seed)) : data[i];
		notes.push_back('{rd, addr[i], data[i]});
		@(negedge clock);
		req_valid = 1'b0;
		while (done !== 1'b1)
			@(negedge clock);
		@(negedge clock);
	endtask : xfer
	// ********
	// Clock, monitor and sequence
	// ********
	initial
	begin
		clock = 1'b0;
		forever
			#20 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			failures++;
			$display("[ERR] %0t timeout", $time);
			report_and_stop();
		end
	end
	always @(negedge clock)
	begin
		if (write_strobe === 1'b1)
			strobes++;
		if (done === 1'b1 && notes.size() > 0)
		begin
			e = notes.pop_front();
			check_word({23'h0, nacked}, 24'h000000);
			if (e.rd)
				check_word(rd_data, e.d);
			if (!e.rd)
				check_word(last_address, e.a);
			if (!e.rd)
				check_word(last_data, e.d);
		end
	end
	initial
	begin
		resetn = 1'b0;
		req_valid = 1'b0;
		req_read = 1'b0;
		req_addr = 24'h000000;
		req_data = 24'h000000;
		seed = 10;
		repeat (4)
			@(negedge clock);
		resetn = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			addr[i] = {6'h00, i[1:0], 12'h000, {4{i[2]}}};
			data[i] = 24'($random(seed));
			xfer(1'b0, i);
		end
		for (int i = 7; i >= 0; i--)
			xfer(1'b1, i);
		check_word(24'(strobes), 24'h000008);
		check_word(24'(notes.size()), 24'h000000);
		report_and_stop();
	end
endmodule : testbench
